// ---- rx_desc_pkg.sv ----
// Shared constants and types for the receive descriptor pointer unit.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package rx_desc_pkg;
  // Register byte offsets
  localparam logic [3:0]  OFF_POINTER      = 4'h0;
  localparam logic [3:0]  OFF_COMMAND      = 4'h4;
  localparam logic [3:0]  OFF_STATUS       = 4'h8;
  // Reset values
  localparam logic [31:0] POINTER_RESET    = 32'h00000002;
  localparam logic [29:0] POINTER_HI_RESET = 30'h00000000;
  localparam logic [1:0]  POINTER_LO_BITS  = 2'h2;
  // Command and status field positions
  localparam int          CMD_ENABLE_BIT   = 0;
  localparam int          STAT_SILENT_BIT  = 0;
  localparam int          STAT_END_BIT     = 1;
  localparam int          STAT_IDLE_BIT    = 2;
  localparam int          STAT_PEND_BIT    = 3;
  // Packet data starts past the descriptor header
  localparam logic [31:0] DESC_HDR_BYTES   = 32'h0000000c;
  localparam int          DATA_W           = 32;
  localparam int          BUF_DEPTH        = 2;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_ACTIVE = 6'b000010,
    ST_DRAIN  = 6'b000100,
    ST_FETCH  = 6'b001000,
    ST_END    = 6'b010000,
    ST_SILENT = 6'b100000
  } rx_state_t;
endpackage

// ---- rx_stream_if.sv ----
// Word stream carrier between the pointer unit and its buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface rx_stream_if;
  import rx_desc_pkg::*;
  logic [DATA_W-1:0] data;
  logic              last;
  logic              valid;
  logic              ready;
  modport src (output data, output last, output valid, input ready);
  modport snk (input data, input last, input valid, output ready);
endinterface
`default_nettype wire

// ---- rx_skid_buffer.sv ----
// Two-entry buffer on the receive word path.
// Assumes a single clock; ce low freezes every entry and flag.
`timescale 1ns/1ps
`default_nettype none
module rx_skid_buffer
  import rx_desc_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst,
  input  wire logic  ce,
  rx_stream_if.snk   fill,
  rx_stream_if.src   drain
);
  logic [DATA_W:0] entry [BUF_DEPTH];
  logic            wr_ptr;
  logic            rd_ptr;
  logic [1:0]      count;
  logic            not_full;
  logic            push;
  logic            pop;
  logic [1:0]      next_count;

  // Handshakes on both sides
  assign push       = fill.valid & not_full;
  assign pop        = drain.valid & drain.ready;
  assign next_count = count + {1'b0, push} - {1'b0, pop};
  assign fill.ready = not_full;
  assign drain.valid = (count != 2'h0);
  assign drain.data = entry[rd_ptr][DATA_W-1:0];
  assign drain.last = entry[rd_ptr][DATA_W];

  // Ready is registered from the next count, so a full buffer stalls the source on time, never late
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count    <= 2'h0;
      not_full <= 1'b1;
      wr_ptr   <= 1'b0;
      rd_ptr   <= 1'b0;
    end else if (ce) begin
      count    <= next_count;
      not_full <= (next_count != 2'h2);
      wr_ptr   <= wr_ptr ^ push;
      rd_ptr   <= rd_ptr ^ pop;
    end
  end

  // One storage slot per entry
  for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_entry
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        entry[i] <= '0;
      end else if (ce && push && (wr_ptr == 1'(i))) begin
        entry[i] <= {fill.last, fill.data};
      end
    end
  end

  // Buffer never accepts a word while full
  a_full_stalls_fill : assert property (@(posedge clock) disable iff (rst)
    (count == 2'h2) |-> !fill.ready)
    else $error("buffer offered ready while full");
endmodule // rx_skid_buffer
`default_nettype wire

// ---- rx_descriptor_pointer_unit.sv ----
// Receive descriptor pointer unit: pointer register, list walk, silent mode.
// Assumes same-clock receive words, a descriptor link reader and a DMA write port.
// Notes on behaviour
// RULE1 - Software loads pointer before enabling, while idle
// RULE2 - Pointer follows descriptor currently being processed
// RULE3 - Null link keeps pointer on current descriptor
// RULE4 - Enable strobe after list end rereads link
// RULE5 - Software writes pointer only while idle; the code accepts a pointer write in any state
// RULE6 - Descriptor addresses word aligned, low bits zero
// RULE7 - Zero pointer plus enable enters silent mode
// RULE8 - Silent mode buffers packets, no DMA at all
// RULE9 - Valid pointer plus enable drains buffered data
// RULE10 - Pointer bits 31..2, low bits fixed, reset
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module rx_descriptor_pointer_unit
  import rx_desc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic [31:0] rx_data,
  input  wire logic        rx_last,
  input  wire logic        rx_valid,
  output var  logic        rx_ready,
  output var  logic        dma_valid,
  input  wire logic        dma_ready,
  output var  logic [31:0] dma_addr,
  output var  logic [31:0] dma_data,
  output var  logic        dma_last,
  output var  logic        desc_req,
  output var  logic [31:0] desc_addr,
  input  wire logic        desc_ack,
  input  wire logic [31:0] desc_link,
  output var  logic        silent_mode
);
  rx_state_t   state;
  rx_state_t   next_state;
  logic [29:0] pointer;
  logic [29:0] next_pointer;
  logic [1:0]  pointer_lo;
  logic        enable_pending;
  logic [15:0] word_count;
  logic        rx_ready_q;

  rx_stream_if s_in ();
  rx_stream_if s_out ();

  // Receive words enter the two-entry buffer
  assign s_in.data  = rx_data;
  assign s_in.last  = rx_last;
  assign s_in.valid = rx_valid;

  rx_skid_buffer u_buffer (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .fill  (s_in.snk),
    .drain (s_out.src)
  );

  // Bus decode
  logic        bus_req;
  logic        bus_done;
  logic        hit_pointer;
  logic        hit_command;
  logic        hit_status;
  logic        wr_pointer;
  logic        wr_enable;
  logic [31:0] status_word;
  logic [31:0] read_mux;

  assign bus_req     = avs_read | avs_write;
  assign bus_done    = bus_req & ~avs_waitrequest;
  assign hit_pointer = (avs_address == OFF_POINTER);
  assign hit_command = (avs_address == OFF_COMMAND);
  assign hit_status  = (avs_address == OFF_STATUS);
  assign wr_pointer  = bus_done & avs_write & hit_pointer;
  assign wr_enable   = bus_done & avs_write & hit_command & avs_byteenable[0]
                     & avs_writedata[CMD_ENABLE_BIT];
  assign status_word = {28'h0000000, enable_pending, (state == ST_IDLE),
                        (state == ST_END), (state == ST_SILENT)};
  // Unmapped offsets read as zero
  assign read_mux    = hit_pointer ? {pointer, pointer_lo} :
                       hit_status  ? status_word : 32'h00000000;

  // One wait cycle per access; data loaded on the same edge that drops waitrequest
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (ce) begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= read_mux;
      end
    end
  end

  // Software pointer write, merged per byte lane
  logic [31:0] sw_pointer;
  logic [31:0] pointer_word;
  assign pointer_word = {pointer, pointer_lo};
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign sw_pointer[b*8 +: 8] = avs_byteenable[b] ? avs_writedata[b*8 +: 8]
                                                     : pointer_word[b*8 +: 8];
  end

  // Link fetch results
  logic link_null;
  logic take_word;
  logic dma_accept;
  assign link_null  = (desc_link[31:2] == 30'h00000000);
  assign dma_accept = dma_valid & dma_ready;
  // RULE8 no transfers silent
  assign take_word  = (state == ST_ACTIVE) & s_out.valid & (~dma_valid | dma_ready);
  assign s_out.ready = take_word;
  assign rx_ready   = rx_ready_q;

  // Mirror of the buffer fill level, so the ready flop already sees this
  // cycle's push and pop; a one-cycle-late copy would let a word drop
  logic [1:0] fill_level;
  logic [1:0] next_fill_level;
  assign next_fill_level = fill_level + {1'b0, s_in.valid & s_in.ready}
                         - {1'b0, s_out.valid & s_out.ready};

  // Next state of the list walk
  always_comb begin
    next_state   = state;
    next_pointer = pointer;
    // RULE5 software write lands in any state, unless a non-null link ack overrides it
    if (wr_pointer) begin
      // RULE6 low address bits dropped
      next_pointer = sw_pointer[31:2];
    end
    case (state)
      ST_IDLE: begin
        // RULE7 zero pointer goes silent
        if (enable_pending) begin
          next_state = (pointer == 30'h00000000) ? ST_SILENT : ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (take_word && s_out.last) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (dma_accept) begin
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (desc_ack) begin
          // RULE3 null link holds pointer
          if (link_null) begin
            next_state = ST_END;
          end else begin
            // RULE2 pointer follows the list
            next_state   = ST_ACTIVE;
            next_pointer = desc_link[31:2];
          end
        end
      end
      ST_END: begin
        // RULE4 strobe rereads the link
        if (enable_pending) begin
          next_state = ST_FETCH;
        end
      end
      ST_SILENT: begin
        // RULE9 valid pointer drains buffer
        if (enable_pending && pointer != 30'h00000000) begin
          next_state = ST_ACTIVE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Strobe is consumed only where the walk waits for it
  logic consume;
  assign consume = enable_pending & ((state == ST_IDLE) | (state == ST_END) | (state == ST_SILENT));

  // RULE10 pointer register and reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state          <= ST_IDLE;
      pointer        <= POINTER_HI_RESET;
      pointer_lo     <= POINTER_LO_BITS;
      enable_pending <= 1'b0;
      fill_level     <= 2'h0;
      rx_ready_q     <= 1'b0;
    end else if (ce) begin
      state          <= next_state;
      pointer        <= next_pointer;
      // A new strobe beats the consume in the same cycle
      enable_pending <= wr_enable | (enable_pending & ~consume);
      fill_level     <= next_fill_level;
      rx_ready_q     <= (next_fill_level != 2'h2);
    end
  end

  // Word offset within the current buffer, restarted per descriptor
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      word_count <= 16'h0000;
    end else if (ce) begin
      if (state == ST_FETCH) begin
        word_count <= 16'h0000;
      end else if (take_word) begin
        word_count <= word_count + 16'h0001;
      end
    end
  end

  // DMA output stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dma_valid <= 1'b0;
      dma_addr  <= 32'h00000000;
      dma_data  <= 32'h00000000;
      dma_last  <= 1'b0;
    end else if (ce) begin
      if (take_word) begin
        dma_valid <= 1'b1;
        dma_addr  <= {pointer, 2'h0} + DESC_HDR_BYTES + {14'h0000, word_count, 2'h0};
        dma_data  <= s_out.data;
        dma_last  <= s_out.last;
      end else if (dma_accept) begin
        dma_valid <= 1'b0;
      end
    end
  end

  // Link fetch request and silent indication
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      desc_req    <= 1'b0;
      desc_addr   <= 32'h00000000;
      silent_mode <= 1'b0;
    end else if (ce) begin
      desc_req    <= (next_state == ST_FETCH) & ~(state == ST_FETCH & desc_ack);
      desc_addr   <= {next_pointer, 2'h0};
      silent_mode <= (next_state == ST_SILENT);
    end
  end

  // Checks
  sequence s_strobe_at_end;
    ce && state == ST_END && enable_pending;
  endsequence

  sequence s_null_ack;
    ce && state == ST_FETCH && desc_ack && link_null;
  endsequence

  a_silent_no_dma : assert property (@(posedge clock) disable iff (rst) // RULE8
    (state == ST_SILENT) |-> !dma_valid && !take_word)
    else $error("DMA activity in silent mode");

  a_null_link_hold : assert property (@(posedge clock) disable iff (rst) // RULE3
    (s_null_ack and !wr_pointer) |=> (state == ST_END) && $stable(pointer))
    else $error("pointer moved on null link");

  a_link_advance : assert property (@(posedge clock) disable iff (rst) // RULE2
    (ce && state == ST_FETCH && desc_ack && !link_null) |=> pointer == $past(desc_link[31:2]))
    else $error("pointer did not follow link");

  a_end_reread : assert property (@(posedge clock) disable iff (rst) // RULE4
    s_strobe_at_end |=> state == ST_FETCH ##0 desc_req)
    else $error("no link reread after strobe");

  a_fetch_current : assert property (@(posedge clock) disable iff (rst) // RULE4
    (state == ST_FETCH && desc_req) |-> desc_addr == {pointer, 2'h0})
    else $error("link fetch not at current descriptor");

  a_zero_silent : assert property (@(posedge clock) disable iff (rst) // RULE7
    (ce && state == ST_IDLE && enable_pending && pointer == 30'h00000000) |=> silent_mode)
    else $error("zero pointer did not enter silent mode");

  a_silent_recover : assert property (@(posedge clock) disable iff (rst) // RULE9
    (ce && state == ST_SILENT && enable_pending && pointer != 30'h00000000) |=> state == ST_ACTIVE)
    else $error("silent mode not left on valid pointer");

  a_low_bits_read : assert property (@(posedge clock) disable iff (rst) // RULE10
    (ce && avs_read && avs_waitrequest && hit_pointer) |=> avs_readdata[1:0] == POINTER_LO_BITS)
    else $error("pointer low bits wrong");

  a_bus_one_wait : assert property (@(posedge clock) disable iff (rst)
    (ce && bus_req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

  a_dma_base_addr : assert property (@(posedge clock) disable iff (rst) // RULE2
    (ce && take_word && word_count == 16'h0000) |=> dma_addr == {$past(pointer), 2'h0} + DESC_HDR_BYTES)
    else $error("DMA not at current descriptor");
endmodule // rx_descriptor_pointer_unit
`default_nettype wire

// ---- rx_host_memory_model.sv ----
// Host memory model: answers link reads slowly and takes DMA writes.
// Assumes the unit's clock and reset; links come from a fixed list ending in tail_link.
`timescale 1ns/1ps
`default_nettype none
module rx_host_memory_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        desc_req,
  input  wire logic [31:0] desc_addr,
  output var  logic        desc_ack,
  output var  logic [31:0] desc_link,
  input  wire logic        dma_valid,
  output var  logic        dma_ready,
  input  wire logic [31:0] dma_addr,
  input  wire logic [31:0] dma_data,
  input  wire logic [31:0] tail_link,
  output var  logic [7:0]  dma_count
);
  logic [31:0] mem [0:255];
  logic [1:0]  delay;
  logic [31:0] link_of;
  assign link_of = (desc_addr == 32'h00000100) ? 32'h00000200 :
                   (desc_addr == 32'h00000200) ? tail_link : 32'h00000000;
  // Slow link answers and a sink that stalls every other cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      desc_ack  <= 1'b0;
      desc_link <= 32'h00000000;
      dma_ready <= 1'b0;
      dma_count <= 8'h00;
      delay     <= 2'h0;
    end else begin
      dma_ready <= ~dma_ready;
      desc_ack  <= 1'b0;
      desc_link <= ~desc_link; // Not held outside the answer cycle
      if (dma_valid && dma_ready) begin
        mem[dma_addr[9:2]] <= dma_data;
        dma_count          <= dma_count + 8'h01;
      end
      if (desc_req && !desc_ack) begin
        delay <= delay + 2'h1;
        if (delay == 2'h2) begin
          desc_ack  <= 1'b1;
          desc_link <= link_of;
          delay     <= 2'h0;
        end
      end
    end
  end
endmodule // rx_host_memory_model
`default_nettype wire

// ---- rx_descriptor_pointer_unit_tb.sv ----
// Bench for the pointer unit: register tasks, silent mode, list walk.
// Assumes the host memory model on the link and DMA side.
`timescale 1ns/1ps
`default_nettype none
module rx_descriptor_pointer_unit_tb;
  import rx_desc_pkg::*;
  logic clock, rst, ce, avs_read, avs_write, avs_waitrequest;
  logic rx_last, rx_valid, rx_ready, dma_valid, dma_ready, dma_last, desc_req, desc_ack, silent_mode;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rx_data, dma_addr, dma_data, desc_addr, desc_link, tail_link, rd;
  logic [7:0]  dma_count;
  int          num_errors, checks, cycles;

  rx_descriptor_pointer_unit u_rx_descriptor_pointer_unit (.clock(clock), .rst(rst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_data(rx_data), .rx_last(rx_last), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_addr(dma_addr), .dma_data(dma_data), .dma_last(dma_last),
    .desc_req(desc_req), .desc_addr(desc_addr), .desc_ack(desc_ack), .desc_link(desc_link),
    .silent_mode(silent_mode));
  rx_host_memory_model u_rx_host_memory_model (.clock(clock), .rst(rst), .desc_req(desc_req),
    .desc_addr(desc_addr), .desc_ack(desc_ack), .desc_link(desc_link), .dma_valid(dma_valid),
    .dma_ready(dma_ready), .dma_addr(dma_addr), .dma_data(dma_data), .tail_link(tail_link),
    .dma_count(dma_count));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Whole Avalon cycle: hold until an edge samples waitrequest low, take data there
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    // Idle edge so the next call never re-raises a strobe in this time step
    @(posedge clock);
  endtask

  // Poll a register until the masked value shows, bounded
  task automatic poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== exp && n < 40);
    chk(rd & m, exp);
  endtask

  // Word is held until an edge sees ready high; a stall only waits
  task automatic send(input logic [31:0] d, input logic l);
    rx_data  <= d;
    rx_last  <= l;
    rx_valid <= 1'b1;
    @(posedge clock);
    while (rx_ready !== 1'b1) @(posedge clock);
    rx_valid <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wait_dma(input logic [7:0] cnt);
    int n;
    n = 0;
    while (dma_count !== cnt && n < 200) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
  endtask

  // Hang guard, far above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    num_errors = 0;
    checks = 0;
    cycles = 0;
    rst = 1'b1;
    ce = 1'b1;
    {avs_read, avs_write, rx_valid, rx_last} = 4'h0;
    {avs_address, avs_writedata, rx_data} = '0;
    tail_link = 32'h00000000;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bus(1'b0, OFF_POINTER, 32'h0);
    chk(rd, 32'h00000002);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(rd[STAT_IDLE_BIT], 1'b1);
    bus(1'b1, OFF_POINTER, 32'hffffffff);
    bus(1'b0, OFF_POINTER, 32'h0);
    chk(rd, 32'hfffffffe);
    bus(1'b0, 4'hc, 32'h0);
    chk(rd, 32'h00000000);
    $display("Register test done");
    // load pointer while idle, zero first
    bus(1'b1, OFF_POINTER, 32'h00000000);
    bus(1'b1, OFF_COMMAND, 32'h00000001);
    poll(OFF_STATUS, 32'h00000001, 32'h00000001);
    chk(silent_mode, 1'b1);
    send(32'h000000a1, 1'b0);
    send(32'h000000a2, 1'b1);
    repeat (10) @(posedge clock);
    chk(dma_count, 8'h00);
    chk(rx_ready, 1'b0);
    $display("Silent test done");
    bus(1'b1, OFF_POINTER, 32'h00000100);
    bus(1'b1, OFF_COMMAND, 32'h00000001);
    wait_dma(8'h02);
    chk(u_rx_host_memory_model.mem[8'h43], 32'h000000a1);
    chk(u_rx_host_memory_model.mem[8'h44], 32'h000000a2);
    chk(dma_last, 1'b1);
    chk(silent_mode, 1'b0);
    poll(OFF_POINTER, 32'hffffffff, 32'h00000202);
    $display("Recovery test done");
    send(32'h000000b1, 1'b1);
    wait_dma(8'h03);
    chk(u_rx_host_memory_model.mem[8'h83], 32'h000000b1);
    poll(OFF_STATUS, 32'h00000002, 32'h00000002);
    bus(1'b0, OFF_POINTER, 32'h0);
    chk(rd, 32'h00000202);
    $display("List end test done");
    tail_link <= 32'h00000300;
    bus(1'b1, OFF_COMMAND, 32'h00000001);
    poll(OFF_POINTER, 32'hffffffff, 32'h00000302);
    $display("Reread test done");
    final_report();
  end
endmodule // rx_descriptor_pointer_unit_tb
`default_nettype wire
